/* File: verilog/counter_pkg.sv */
package counter_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int COUNT_WIDTH = 8;
    localparam int SYNC_STAGES = 3;

    // ==========================================================
    // Clock
    // ==========================================================
    localparam int REF_CLK_PERIOD_PS = 5000;

    // ==========================================================
    // Reset values and the all-ones carry compare value
    // ==========================================================
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic CARRY_N_RESET = 1'b1;
    localparam logic OE_RESET = 1'b0;

    // ==========================================================
    // Sampled input bus layout
    // ==========================================================
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_COUNT_CLK = 8;
    localparam int PIN_HOLD_CLK = 9;
    localparam int PIN_CLEAR_N = 10;
    localparam int PIN_EN_N = 11;
    localparam int PIN_EN_HI = 12;
    localparam int PIN_HOLD_EN_N = 13;
    localparam int PIN_LOAD_N = 14;
    localparam int PIN_OE_HI = 15;
    localparam int PIN_OE_N = 16;
    localparam int PIN_WIDTH = 17;
    // Idle levels seen on the sampled bus before the first pin sample
    // Active-low pins idle high, active-high ones low, so no output enable or
    // count enable is seen while the sampler fills after reset
    localparam logic [16:0] PIN_IDLE = 17'h16c00;

endpackage

/* File: verilog/pin_sampler.sv */
module pin_sampler #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    // ==========================================================
    // Three-stage sampler with agreement filter
    // ==========================================================
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] held_r;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] held_nxt;

    // A bit only moves once two settled stages agree, so a glitch is dropped
    assign agree = ~(stage2_r ^ stage3_r);
    assign held_nxt = (stage2_r & agree) | (held_r & ~agree);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1_r <= IDLE;
            stage2_r <= IDLE;
            stage3_r <= IDLE;
            held_r <= IDLE;
        end else begin
            stage1_r <= pin_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            held_r <= held_nxt;
        end
    end

    assign pin_out = held_r;

endmodule

/* File: verilog/counter_with_input_register.sv */
// How it works
// - An 8-bit hold register feeds the counter, which loads from it.
// - Counter is synchronous; all eight bits change together on a count clock edge.
// - Hold register has its own data inputs, separate from the counter outputs.
// - Counter outputs are three-state, with output enable for bus sharing.
// - Counter and hold register each have an independent clock input.
// - Both clocks act on the rising edge only.
// - Active-low clear zeroes the counter without any count clock edge.
// - Counter advances on a count clock edge only while count_enable_n is low and count_enable_hi is high.
// - Active-low carry out marks all ones; chain it to the next enable.
// - With clocks tied, counter after an edge equals prior register plus one.
// - Enable changes alone never advance the counter; only a clock edge does.
// - Counter counts upward only; there is no direction control.
module counter_with_input_register #(
    parameter int WIDTH = counter_pkg::COUNT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] hold_data_in,
    input wire logic count_clock,
    input wire logic hold_reg_clock,
    input wire logic count_clear_n,
    input wire logic count_enable_n,
    input wire logic count_enable_hi,
    input wire logic hold_reg_enable_n,
    input wire logic count_load_n,
    input wire logic output_enable_hi,
    input wire logic output_enable_n,
    output logic [WIDTH-1:0] count_out,
    output logic [WIDTH-1:0] count_out_oe,
    output logic carry_out_n
);

    // ==========================================================
    // Elaboration check
    // ==========================================================
    if (WIDTH != counter_pkg::COUNT_WIDTH) begin : g_bad_width
        $error("counter width must be 8");
    end

    // ==========================================================
    // Input sampling
    // ==========================================================
    // All pins share one sampler so data and clocks keep their alignment
    logic [counter_pkg::PIN_WIDTH-1:0] pins_raw;
    logic [counter_pkg::PIN_WIDTH-1:0] pins;

    assign pins_raw = {output_enable_n, output_enable_hi, count_load_n,
                       hold_reg_enable_n, count_enable_hi, count_enable_n,
                       count_clear_n, hold_reg_clock, count_clock, hold_data_in};

    pin_sampler #(
        .WIDTH(counter_pkg::PIN_WIDTH),
        .IDLE(counter_pkg::PIN_IDLE)
    ) u_pins (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(pins_raw),
        .pin_out(pins)
    );

    // ==========================================================
    // Decoded controls
    // ==========================================================
    logic [WIDTH-1:0] data_s;
    logic count_clk_s;
    logic hold_clk_s;
    logic count_clk_prev_r;
    logic hold_clk_prev_r;
    logic count_edge;
    logic hold_edge;
    logic clear_act;
    logic load_act;
    logic count_act;
    logic hold_act;
    logic oe_act;

    assign data_s = pins[counter_pkg::PIN_DATA_LSB +: WIDTH];
    assign count_clk_s = pins[counter_pkg::PIN_COUNT_CLK];
    assign hold_clk_s = pins[counter_pkg::PIN_HOLD_CLK];

    // Rising edges only; falling edges are ignored
    assign count_edge = count_clk_s & ~count_clk_prev_r;
    assign hold_edge = hold_clk_s & ~hold_clk_prev_r;

    assign clear_act = ~pins[counter_pkg::PIN_CLEAR_N];
    assign load_act = ~pins[counter_pkg::PIN_LOAD_N];
    // Enables only qualify an edge, they never create one
    assign count_act = count_edge & ~pins[counter_pkg::PIN_EN_N]
                       & pins[counter_pkg::PIN_EN_HI];
    assign hold_act = hold_edge & ~pins[counter_pkg::PIN_HOLD_EN_N];
    assign oe_act = ~pins[counter_pkg::PIN_OE_N] | pins[counter_pkg::PIN_OE_HI];

    // ==========================================================
    // Hold register and counter
    // ==========================================================
    logic [WIDTH-1:0] hold_r;
    logic [WIDTH-1:0] hold_nxt;
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic carry_n_r;
    logic oe_r;
    logic tie_act;

    // Shared by the plain count and the tied-clock count
    function automatic logic [WIDTH-1:0] incr(input logic [WIDTH-1:0] v);
        return v + WIDTH'(1);
    endfunction

    // Clear empties the hold register as well as the counter
    assign hold_nxt = clear_act ? counter_pkg::HOLD_RESET :
                      hold_act ? data_s : hold_r;

    // Clear over load over count; a count edge that meets a hold clock edge
    // starts from the pre-edge hold contents, so tied clocks run one ahead
    assign tie_act = count_act & hold_edge;
    assign count_nxt = clear_act ? counter_pkg::COUNT_RESET :
                       load_act ? hold_r :
                       tie_act ? incr(hold_r) :
                       count_act ? incr(count_r) :
                       count_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_clk_prev_r <= 1'b0;
            hold_clk_prev_r <= 1'b0;
        end else begin
            count_clk_prev_r <= count_clk_s;
            hold_clk_prev_r <= hold_clk_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_r <= counter_pkg::HOLD_RESET;
            count_r <= counter_pkg::COUNT_RESET;
        end else begin
            hold_r <= hold_nxt;
            count_r <= count_nxt;
        end
    end

    // Registered from the next count so carry stays aligned with count_out
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            carry_n_r <= counter_pkg::CARRY_N_RESET;
            oe_r <= counter_pkg::OE_RESET;
        end else begin
            carry_n_r <= ~(count_nxt == counter_pkg::ALL_ONES);
            oe_r <= oe_act;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign count_out = count_r;
    assign count_out_oe = {WIDTH{oe_r}};
    assign carry_out_n = carry_n_r;

endmodule

/* File: sim/counter_chk.sv */
module counter_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic count_clock,
    input wire logic hold_reg_clock,
    input wire logic count_clear_n,
    input wire logic count_enable_n,
    input wire logic count_enable_hi,
    input wire logic hold_reg_enable_n,
    input wire logic count_load_n,
    input wire logic output_enable_hi,
    input wire logic output_enable_n,
    input wire logic [7:0] count_out,
    input wire logic [7:0] count_out_oe,
    input wire logic carry_out_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ====
    // Pins seen raw, so windows span the pin sampler
    // Tied clocks restart from the hold contents, so such windows are no plain step
    wire tied = count_clock && hold_reg_clock;
    wire run = count_clear_n && count_load_n && !tied;
    wire go = !count_enable_n && count_enable_hi;
    wire oe = output_enable_hi || !output_enable_n;
    property p_clr; (!count_clear_n)[*6] |-> count_out == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("clear missed");
    property p_rco; carry_out_n == (count_out != 8'hff); endproperty
    a_rco: assert property (p_rco) else $error("carry wrong");
    property p_on; oe[*6] |-> count_out_oe == 8'hff; endproperty
    a_on: assert property (p_on) else $error("not driven");
    property p_off; (!oe)[*6] |-> count_out_oe == 8'h00; endproperty
    a_off: assert property (p_off) else $error("not released");
    property p_stp; run[*6] |-> count_out inside {$past(count_out), $past(count_out) + 8'h01};
    endproperty
    a_stp: assert property (p_stp) else $error("bad step");
    property p_gate; (run && !go)[*6] |-> $stable(count_out); endproperty
    a_gate: assert property (p_gate) else $error("counted disabled");
    property p_inc; $rose(count_clock) && go && run ##1 run[*4] |->
        ##1 count_out == $past(count_out) + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("no count");
    property p_ld; (!count_load_n && count_clear_n && hold_reg_enable_n)[*8] |->
        $stable(count_out); endproperty
    a_ld: assert property (p_ld) else $error("load moved");
    c_wrap: cover property ($fell(carry_out_n));
    c_cnt: cover property ($rose(count_clock) && go);
    c_ld: cover property ((!count_load_n)[*8]);
endmodule
bind counter_with_input_register counter_chk i_chk (.*);

/* File: sim/pin_partner.sv */
module pin_partner (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] fire,
    output logic count_clock,
    output logic hold_reg_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] span_r;
    logic [1:0] sel_r;
    // ====
    // Four high, four low: each level outlives the pin sampler
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            span_r <= 3'h0;
            sel_r <= 2'h0;
        end else if (span_r != 3'h0) begin
            span_r <= span_r - 3'h1;
        end else if (fire != 2'h0) begin
            span_r <= 3'h7;
            sel_r <= fire;
        end
    end
    assign count_clock = sel_r[0] && span_r[2];
    assign hold_reg_clock = sel_r[1] && span_r[2];
endmodule

/* File: sim/counter_with_input_register_test.sv */
module counter_with_input_register_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, rst = 1'b1, count_clock, hold_reg_clock, carry_out_n;
    logic count_clear_n = 1'b1, count_enable_n = 1'b0, count_enable_hi = 1'b1;
    logic hold_reg_enable_n = 1'b1, count_load_n = 1'b1;
    logic output_enable_hi = 1'b0, output_enable_n = 1'b1;
    logic [7:0] hold_data_in = 8'h00, count_out, count_out_oe, hold = 8'h00, cnt = 8'h00;
    logic [1:0] fire = 2'h0;
    int err_count = 0, total_checks = 0;
    counter_with_input_register i_dut (.*);
    pin_partner i_far (.*);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ====
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(input logic [1:0] f);
        fire = f;
        cyc(1);
        fire = 2'h0;
        cyc(12);
    endtask
    task automatic wr(input logic [7:0] d, input logic en_n);
        hold_data_in = d;
        hold_reg_enable_n = en_n;
        pulse(2'h2);
        hold_reg_enable_n = 1'b1;
        hold = en_n ? hold : d;
    endtask
    task automatic load();
        count_load_n = 1'b0;
        cyc(8);
        count_load_n = 1'b1;
        cyc(6);
        cnt = hold;
    endtask
    function automatic logic [7:0] nxt(logic [7:0] c);
        return (!count_enable_n && count_enable_hi) ? c + 8'h01 : c;
    endfunction
    task automatic end_sim();
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'he81e88a3));
        cyc(6);
        rst = 1'b0;
        cyc(6);
        chk({carry_out_n, count_out[6:0]}, 8'h80);
        wr(8'h5a, 1'b1);
        load();
        chk(count_out, 8'h00);
        wr(8'($urandom), 1'b0);
        load();
        chk(count_out, hold);
        for (int i = 0; i < 24; i++) begin
            {count_enable_n, count_enable_hi} = 2'($urandom);
            pulse(2'h1);
            cnt = nxt(cnt);
            chk(count_out, cnt);
            count_enable_n = ~count_enable_n;
            cyc(6);
            chk(count_out, cnt);
        end
        wr(8'hfe, 1'b0);
        load();
        {count_enable_n, count_enable_hi} = 2'h1;
        for (int i = 0; i < 2; i++) begin
            pulse(2'h1);
            cnt = nxt(cnt);
            chk(count_out, cnt);
            chk({7'h00, carry_out_n}, {7'h00, cnt != 8'hff});
        end
        hold_data_in = 8'($urandom);
        hold_reg_enable_n = 1'b0;
        pulse(2'h3);
        chk(count_out, 8'hff);
        hold = hold_data_in;
        hold_reg_enable_n = 1'b1;
        // A count edge while load is held low must not move the counter off the hold value
        count_load_n = 1'b0;
        pulse(2'h1);
        chk(count_out, hold);
        count_load_n = 1'b1;
        cyc(6);
        count_clear_n = 1'b0;
        cyc(6);
        chk(count_out, 8'h00);
        count_clear_n = 1'b1;
        hold = 8'h00;
        load();
        chk(count_out, hold);
        for (int i = 0; i < 4; i++) begin
            {output_enable_hi, output_enable_n} = 2'(i);
            cyc(6);
            chk(count_out_oe, {8{output_enable_hi | !output_enable_n}});
        end
        end_sim();
    end
    // Run needs about 3.3 us; six times that means a hang
    initial begin
        #20000;
        err_count++;
        end_sim();
    end
endmodule
